// ===== rtl/awseq_top.sv
// Chosen here: register access over AHB-Lite.
`timescale 1ns/1ps

// Overview of operation
// - Opcodes 30h and 31h start sector write.
// - Opcode CDh runs as plain sector write.
// - Opcode 38h runs as plain sector write.
// - Opcode 3Ch runs as plain sector write.
// - Sector count register sets sectors, 1 to 256.
// - Count zero means 256 sectors.
// - Start at addressed sector, continue consecutively.
// - LBA is head, track high, track low, sector.
// - Accept sets busy, then request clears busy.
// - No interrupt on first data request.
// - Full sector received sets busy, clears request.
// - Next buffer ready: request, interrupt, busy cleared.
// - Busy clears after last sector; completion interrupts.
// - Error stops at failing sector, address kept.
module awseq_top
    import awseq_pkg::*;
#(
    parameter int SECTORS_PER_TRACK = 32,
    parameter int HEAD_COUNT = 16
)
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic media_done,
    input wire logic media_fail,
    input wire logic [WORD_W-1:0] media_rd_addr,
    output logic media_start,
    output logic [27:0] media_lba,
    output logic media_lba_mode,
    output logic [15:0] media_rd_data,
    output logic busy,
    output logic drq,
    output logic irq
);

    if (SECTORS_PER_TRACK < 1 || SECTORS_PER_TRACK > 255 ||
        HEAD_COUNT < 1 || HEAD_COUNT > 16)
    begin : g_bad_geometry
        $error("Geometry parameters out of range.");
    end

    localparam logic [7:0] SPT_LAST = 8'(SECTORS_PER_TRACK);
    localparam logic [3:0] HEAD_LAST = 4'(HEAD_COUNT - 1);

    ////////////////////////////////////////////////////////////////////////

    awseq_bus_t req_reg;
    logic hreadyout_reg;
    logic hresp_reg;
    logic [31:0] hrdata_reg;
    awseq_task_t task_reg;
    awseq_task_t task_adv;
    awseq_state_t state_reg;
    logic busy_reg;
    logic drq_reg;
    logic err_reg;
    logic [8:0] remaining_reg;
    logic [WORD_W-1:0] word_reg;
    logic [15:0] sector_buf [WORDS_PER_SECTOR];
    logic media_start_reg;
    logic [27:0] media_lba_reg;
    logic media_lba_mode_reg;
    logic [15:0] media_rd_data_reg;
    logic [IRQ_W-1:0] irq_stat_reg;
    logic [IRQ_W-1:0] irq_en_reg;
    logic [IRQ_W-1:0] irq_stat_next;
    logic [IRQ_W-1:0] irq_event;
    logic [IRQ_W-1:0] irq_clr;
    logic irq_reg;
    logic addr_take;
    logic wr_en;
    logic cmd_go;
    logic data_wr;
    logic prog_ok;
    logic prog_fail;
    logic last_sector;
    logic [7:0] rd_value;

    function automatic logic [27:0] block_address(input awseq_task_t t);
        return {t.drive_head[3:0], t.track_high, t.track_low, t.sector};
    endfunction

    function automatic logic is_write_op(input logic [7:0] op);
        return op == OP_WRITE || op == OP_WRITE_ALT ||
            op == OP_WRITE_NO_ERASE || op == OP_WRITE_VERIFY ||
            op == OP_MULTI_NO_ERASE;
    endfunction

    // Next consecutive sector, in LBA or in cylinder/head/sector terms.
    function automatic awseq_task_t advance(input awseq_task_t t);
        awseq_task_t n;
        logic [27:0] lba;
        logic [15:0] trk;
        n = t;
        lba = block_address(t) + 28'h1;
        trk = {t.track_high, t.track_low} + 16'h1;
        if (t.drive_head[DH_LBA_BIT])
        begin
            n.drive_head[3:0] = lba[27:24];
            n.track_high = lba[23:16];
            n.track_low = lba[15:8];
            n.sector = lba[7:0];
        end
        else if (t.sector >= SPT_LAST)
        begin
            n.sector = 8'h01;
            if (t.drive_head[3:0] >= HEAD_LAST)
            begin
                n.drive_head[3:0] = 4'h0;
                n.track_high = trk[15:8];
                n.track_low = trk[7:0];
            end
            else
            begin
                n.drive_head[3:0] = t.drive_head[3:0] + 4'h1;
            end
        end
        else
        begin
            n.sector = t.sector + 8'h1;
        end
        n.count = t.count - 8'h1;
        return n;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Bus slave: zero wait states, always OKAY; non-word transfers ignored.

    assign addr_take = hsel && htrans[1] && hready && hsize == HSIZE_WORD;
    assign wr_en = req_reg.valid && req_reg.write;
    assign cmd_go = wr_en && req_reg.index == IDX_OPCODE &&
        state_reg == SEQ_IDLE && is_write_op(hwdata[7:0]);
    // Data only lands while a sector is requested.
    assign data_wr = wr_en && req_reg.index == IDX_DATA &&
        state_reg == SEQ_XFER;
    assign prog_ok = state_reg == SEQ_PROG && media_done && !media_fail;
    assign prog_fail = state_reg == SEQ_PROG && media_done && media_fail;
    assign last_sector = remaining_reg == 9'h001;
    assign task_adv = advance(task_reg);

    always_comb
    begin
        case (haddr[BUS_IDX_LSB +: IDX_W])
            IDX_COUNT: rd_value = task_reg.count;
            IDX_SECTOR: rd_value = task_reg.sector;
            IDX_TRACK_LO: rd_value = task_reg.track_low;
            IDX_TRACK_HI: rd_value = task_reg.track_high;
            IDX_DRIVE_HEAD: rd_value = task_reg.drive_head;
            IDX_STATUS: rd_value = {5'h00, err_reg, drq_reg, busy_reg};
            IDX_IRQ_STAT: rd_value = {5'h00, irq_stat_reg};
            IDX_IRQ_EN: rd_value = {5'h00, irq_en_reg};
            default: rd_value = 8'h00;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            req_reg <= '0;
            hrdata_reg <= 32'h0000_0000;
            hreadyout_reg <= 1'b1;
            hresp_reg <= 1'b0;
        end
        else if (ce)
        begin
            req_reg <= '{valid: addr_take, write: hwrite,
                index: haddr[BUS_IDX_LSB +: IDX_W]};
            if (addr_take && !hwrite)
            begin
                hrdata_reg <= {24'h00_0000, rd_value};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Task file. Software writes only land while idle, so the sequencer
    // owns the address while a command runs.

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            task_reg <= {5{TASK_RESET}};
        end
        else if (ce)
        begin
            if (wr_en && state_reg == SEQ_IDLE)
            begin
                case (req_reg.index)
                    // Accepted and dropped, since no write command uses it.
                    IDX_FEATURE: task_reg <= task_reg;
                    IDX_COUNT: task_reg.count <= hwdata[7:0];
                    IDX_SECTOR: task_reg.sector <= hwdata[7:0];
                    IDX_TRACK_LO: task_reg.track_low <= hwdata[7:0];
                    IDX_TRACK_HI: task_reg.track_high <= hwdata[7:0];
                    IDX_DRIVE_HEAD: task_reg.drive_head <= hwdata[7:0];
                    default: task_reg <= task_reg;
                endcase
            end
            else if (prog_ok && last_sector)
            begin
                task_reg.count <= task_adv.count;
            end
            else if (prog_ok)
            begin
                task_reg <= task_adv;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Command sequencer.

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_reg <= SEQ_IDLE;
            busy_reg <= 1'b0;
            drq_reg <= 1'b0;
            err_reg <= 1'b0;
            remaining_reg <= 9'h000;
            word_reg <= '0;
            media_start_reg <= 1'b0;
        end
        else if (ce)
        begin
            media_start_reg <= 1'b0;
            case (state_reg)
                SEQ_IDLE:
                begin
                    // All five opcodes share one path.
                    if (cmd_go)
                    begin
                        state_reg <= SEQ_ACCEPT;
                        busy_reg <= 1'b1;
                        drq_reg <= 1'b0;
                        err_reg <= 1'b0;
                        word_reg <= '0;
                        remaining_reg <= (task_reg.count == 8'h00) ?
                            MAX_SECTORS : {1'b0, task_reg.count};
                    end
                end
                SEQ_ACCEPT:
                begin
                    state_reg <= SEQ_XFER;
                    busy_reg <= 1'b0;
                    drq_reg <= 1'b1;
                end
                SEQ_XFER:
                begin
                    if (data_wr)
                    begin
                        word_reg <= word_reg + 1'b1;
                        if (word_reg == LAST_WORD)
                        begin
                            state_reg <= SEQ_PROG;
                            busy_reg <= 1'b1;
                            drq_reg <= 1'b0;
                            media_start_reg <= 1'b1;
                        end
                    end
                end
                SEQ_PROG:
                begin
                    if (prog_fail)
                    begin
                        // The address still names the failing sector.
                        state_reg <= SEQ_IDLE;
                        busy_reg <= 1'b0;
                        err_reg <= 1'b1;
                    end
                    else if (prog_ok && last_sector)
                    begin
                        state_reg <= SEQ_IDLE;
                        busy_reg <= 1'b0;
                        remaining_reg <= remaining_reg - 9'h001;
                    end
                    else if (prog_ok)
                    begin
                        state_reg <= SEQ_XFER;
                        busy_reg <= 1'b0;
                        drq_reg <= 1'b1;
                        word_reg <= '0;
                        remaining_reg <= remaining_reg - 9'h001;
                    end
                end
                default:
                begin
                    state_reg <= SEQ_IDLE;
                    busy_reg <= 1'b0;
                    drq_reg <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sector buffer. A single buffer keeps area small, so the media side
    // must finish reading it before it signals media_done.

    always_ff @(posedge hclk)
    begin
        if (ce && data_wr)
        begin
            sector_buf[word_reg] <= hwdata[15:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            media_rd_data_reg <= 16'h0000;
            media_lba_reg <= 28'h000_0000;
            media_lba_mode_reg <= 1'b0;
        end
        else if (ce)
        begin
            media_rd_data_reg <= sector_buf[media_rd_addr];
            if (data_wr && word_reg == LAST_WORD)
            begin
                media_lba_reg <= block_address(task_reg);
                media_lba_mode_reg <= task_reg.drive_head[DH_LBA_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupts. A new event wins over a clear in the same cycle.

    always_comb
    begin
        irq_event = '0;
        irq_event[IRQ_NEXT] = prog_ok && !last_sector;
        irq_event[IRQ_DONE] = prog_ok && last_sector;
        irq_event[IRQ_ERR] = prog_fail;
        irq_clr = (wr_en && req_reg.index == IDX_IRQ_CLR) ?
            hwdata[IRQ_W-1:0] : '0;
        irq_stat_next = (irq_stat_reg & ~irq_clr) | irq_event;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            irq_stat_reg <= '0;
            irq_en_reg <= IRQ_EN_RESET;
            irq_reg <= 1'b0;
        end
        else if (ce)
        begin
            irq_stat_reg <= irq_stat_next;
            irq_reg <= |(irq_stat_next & irq_en_reg);
            if (wr_en && req_reg.index == IDX_IRQ_EN)
            begin
                irq_en_reg <= hwdata[IRQ_W-1:0];
            end
        end
    end

    assign hreadyout = hreadyout_reg;
    assign hresp = hresp_reg;
    assign hrdata = hrdata_reg;
    assign media_start = media_start_reg;
    assign media_lba = media_lba_reg;
    assign media_lba_mode = media_lba_mode_reg;
    assign media_rd_data = media_rd_data_reg;
    assign busy = busy_reg;
    assign drq = drq_reg;
    assign irq = irq_reg;

    ////////////////////////////////////////////////////////////////////////

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    chk_opcode_accept: assert property (
        (ce && cmd_go) |=> busy_reg && !drq_reg && state_reg == SEQ_ACCEPT)
        else $error("Write opcode not accepted.");

    chk_count_zero: assert property (
        (ce && cmd_go && task_reg.count == 8'h00)
        |=> remaining_reg == 9'h100)
        else $error("Count zero did not give 256 sectors.");

    chk_count_load: assert property (
        (ce && cmd_go && task_reg.count != 8'h00)
        |=> remaining_reg == {1'b0, $past(task_reg.count)})
        else $error("Sector count not loaded.");

    chk_accept_drq: assert property (
        (ce && state_reg == SEQ_ACCEPT) |=> drq_reg && !busy_reg)
        else $error("Request not raised after accept.");

    chk_first_quiet: assert property (
        (ce && state_reg == SEQ_ACCEPT && !irq_stat_reg[IRQ_NEXT])
        |=> !irq_stat_reg[IRQ_NEXT])
        else $error("Interrupt on first data request.");

    chk_sector_full: assert property (
        (ce && data_wr && word_reg == LAST_WORD)
        |=> busy_reg && !drq_reg && media_start_reg)
        else $error("Full sector did not raise busy.");

    chk_lba_layout: assert property (
        media_start_reg |-> media_lba_reg == {task_reg.drive_head[3:0],
            task_reg.track_high, task_reg.track_low, task_reg.sector})
        else $error("Block address assembled wrongly.");

    chk_next_sector: assert property (
        (ce && prog_ok && !last_sector)
        |=> drq_reg && !busy_reg && irq_stat_reg[IRQ_NEXT] && word_reg == '0)
        else $error("Next sector not requested.");

    chk_complete: assert property (
        (ce && prog_ok && last_sector)
        |=> !busy_reg && !drq_reg && irq_stat_reg[IRQ_DONE])
        else $error("Completion not signalled.");

    chk_error_stop: assert property (
        (ce && prog_fail)
        |=> err_reg && !busy_reg && !drq_reg && $stable(task_reg))
        else $error("Error did not stop at failing sector.");

    cov_full_count: cover property (ce && cmd_go && task_reg.count == 8'h00);
    cov_multi: cover property (ce && prog_ok && !last_sector);
    cov_done: cover property (ce && prog_ok && last_sector);
    cov_fail: cover property (ce && prog_fail);

endmodule

// ===== rtl/awseq_pkg.sv
package awseq_pkg;

    // Register indices; the byte address of each is four times its index.
    localparam int IDX_W = 4;
    localparam int BUS_IDX_LSB = 2;
    localparam logic [IDX_W-1:0] IDX_DATA = 4'h0;
    localparam logic [IDX_W-1:0] IDX_FEATURE = 4'h1;
    localparam logic [IDX_W-1:0] IDX_COUNT = 4'h2;
    localparam logic [IDX_W-1:0] IDX_SECTOR = 4'h3;
    localparam logic [IDX_W-1:0] IDX_TRACK_LO = 4'h4;
    localparam logic [IDX_W-1:0] IDX_TRACK_HI = 4'h5;
    localparam logic [IDX_W-1:0] IDX_DRIVE_HEAD = 4'h6;
    localparam logic [IDX_W-1:0] IDX_OPCODE = 4'h7;
    localparam logic [IDX_W-1:0] IDX_STATUS = 4'h8;
    localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 4'h9;
    localparam logic [IDX_W-1:0] IDX_IRQ_CLR = 4'ha;
    localparam logic [IDX_W-1:0] IDX_IRQ_EN = 4'hb;

    localparam logic [2:0] HSIZE_WORD = 3'h2;

    // Accepted write opcodes.
    localparam logic [7:0] OP_WRITE = 8'h30;
    localparam logic [7:0] OP_WRITE_ALT = 8'h31;
    localparam logic [7:0] OP_WRITE_NO_ERASE = 8'h38;
    localparam logic [7:0] OP_WRITE_VERIFY = 8'h3c;
    localparam logic [7:0] OP_MULTI_NO_ERASE = 8'hcd;

    // Field positions and reset values.
    localparam logic [7:0] TASK_RESET = 8'h00;
    localparam int DH_LBA_BIT = 6;
    localparam int STAT_BUSY = 0;
    localparam int STAT_DRQ = 1;
    localparam int STAT_ERR = 2;
    localparam int IRQ_W = 3;
    localparam int IRQ_NEXT = 0;
    localparam int IRQ_DONE = 1;
    localparam int IRQ_ERR = 2;
    localparam logic [IRQ_W-1:0] IRQ_EN_RESET = 3'h0;

    // Sector geometry and counts.
    localparam int WORDS_PER_SECTOR = 256;
    localparam int WORD_W = $clog2(WORDS_PER_SECTOR);
    localparam logic [WORD_W-1:0] LAST_WORD = 8'hff;
    localparam logic [8:0] MAX_SECTORS = 9'h100;

    typedef struct packed {
        logic [7:0] drive_head;
        logic [7:0] track_high;
        logic [7:0] track_low;
        logic [7:0] sector;
        logic [7:0] count;
    } awseq_task_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [IDX_W-1:0] index;
    } awseq_bus_t;

    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_ACCEPT,
        SEQ_XFER,
        SEQ_PROG
    } awseq_state_t;

endpackage

// ===== test/awseq_media_model.sv
`timescale 1ns/1ps

module awseq_media_model
    import awseq_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic media_start,
    input wire logic [15:0] media_rd_data,
    input wire logic fail_req,
    input wire logic [7:0] delay,
    output logic media_done,
    output logic media_fail,
    output logic [WORD_W-1:0] media_rd_addr,
    output logic [15:0] first_word,
    output logic [15:0] sum_word
);

    ////////////////////////////////////////////////////////////////////////
    logic active;
    logic [9:0] cnt;

    // The whole buffer is read before completion is reported, since the
    // card may reuse it as soon as the done pulse is seen.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            active <= 1'b0;
            cnt <= 10'h0;
            media_done <= 1'b0;
            media_fail <= 1'b0;
            media_rd_addr <= 8'h0;
            first_word <= 16'h0;
            sum_word <= 16'h0;
        end
        else
        begin
            media_done <= 1'b0;
            media_fail <= 1'b0;
            if (media_start)
            begin
                active <= 1'b1;
                cnt <= 10'h0;
                sum_word <= 16'h0;
                media_rd_addr <= 8'h0;
            end
            else if (active)
            begin
                cnt <= cnt + 10'h1;
                media_rd_addr <= cnt[7:0] + 8'h1;
                if (cnt == 10'h1)
                begin
                    first_word <= media_rd_data;
                end
                if (cnt >= 10'h1 && cnt <= 10'h100)
                begin
                    sum_word <= sum_word + media_rd_data;
                end
                if (cnt == 10'h100 + {2'h0, delay})
                begin
                    media_done <= 1'b1;
                    media_fail <= fail_req;
                    active <= 1'b0;
                end
            end
        end
    end

endmodule

// ===== test/awseq_top_tb_top.sv
`timescale 1ns/1ps

`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin mismatches++; $display("MISMATCH %s exp %0h seen %0h", n, e, g); end end

module awseq_top_tb_top
    import awseq_pkg::*;
;

    ////////////////////////////////////////////////////////////////////////
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic ce = 1'b1;
    logic hwrite = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = HSIZE_WORD;
    logic fail_req = 1'b0;
    logic [7:0] delay = 8'h4;
    logic hreadyout, hresp, media_start, media_lba_mode, busy, drq, irq;
    logic media_done, media_fail;
    logic [31:0] hrdata, rd;
    logic [27:0] media_lba;
    logic [15:0] media_rd_data, first_word, sum_word;
    logic [WORD_W-1:0] media_rd_addr;
    int mismatches = 0;
    int num_checks = 0;

    awseq_top awseq_top_i (.hclk(hclk), .hresetn(hresetn), .ce(ce),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .media_done(media_done), .media_fail(media_fail),
        .media_rd_addr(media_rd_addr), .media_start(media_start),
        .media_lba(media_lba), .media_lba_mode(media_lba_mode),
        .media_rd_data(media_rd_data), .busy(busy), .drq(drq), .irq(irq));

    awseq_media_model awseq_media_model_i (.clk(hclk), .rstn(hresetn),
        .media_start(media_start), .media_rd_data(media_rd_data),
        .fail_req(fail_req), .delay(delay), .media_done(media_done),
        .media_fail(media_fail), .media_rd_addr(media_rd_addr),
        .first_word(first_word), .sum_word(sum_word));

    initial
    begin
        forever #10 hclk = ~hclk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic bus(input logic w, input logic [3:0] idx,
                       input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {26'h0, idx, 2'h0};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic rchk(input string n, input logic [3:0] idx,
                        input logic [7:0] e);
        logic [31:0] ex;
        ex = {24'h0, e};
        bus(1'b0, idx, 32'h0);
        `CHK(n, ex, rd)
        `CHK("hresp", 1'b0, hresp)
    endtask

    task automatic start(input logic [7:0] op, cnt, sec, lo, hi, dh);
        logic seen;
        seen = 1'b0;
        bus(1'b1, IDX_FEATURE, 32'hff);
        bus(1'b1, IDX_COUNT, {24'h0, cnt});
        bus(1'b1, IDX_SECTOR, {24'h0, sec});
        bus(1'b1, IDX_TRACK_LO, {24'h0, lo});
        bus(1'b1, IDX_TRACK_HI, {24'h0, hi});
        bus(1'b1, IDX_DRIVE_HEAD, {24'h0, dh});
        bus(1'b1, IDX_OPCODE, {24'h0, op});
        // No data goes out before the request shows.
        for (int i = 0; i < 50 && drq !== 1'b1; i++)
        begin
            @(negedge hclk);
            if (busy === 1'b1)
            begin
                seen = 1'b1;
            end
        end
        `CHK("busy before drq", 1'b1, seen)
        `CHK("busy with drq", 1'b0, busy)
        `CHK("drq raised", 1'b1, drq)
        @(posedge hclk);
        rchk("no first irq", IDX_IRQ_STAT, 8'h0);
    endtask

    task automatic sector(input logic [15:0] b);
        logic [15:0] s;
        int k;
        s = 16'h0;
        k = 0;
        for (int i = 0; i < 256; i++)
        begin
            bus(1'b1, IDX_DATA, {16'h0, b + 16'(i)});
            s = s + b + 16'(i);
        end
        // Two edges, so either launch edge of the flags is covered.
        repeat (2) @(negedge hclk);
        `CHK("busy after fill", 1'b1, busy)
        `CHK("drq after fill", 1'b0, drq)
        while (busy === 1'b1 && k < 3000)
        begin
            `CHK("drq while prog", 1'b0, drq)
            @(negedge hclk);
            k++;
        end
        `CHK("prog finished", 1'b0, busy)
        @(posedge hclk);
        `CHK("first word", b, first_word)
        `CHK("word sum", s, sum_word)
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic test_reset;
        rchk("status", IDX_STATUS, 8'h0);
        rchk("irq en", IDX_IRQ_EN, 8'h0);
        rchk("count", IDX_COUNT, 8'h0);
        rchk("unmapped", 4'hc, 8'h0);
        // A write made while the clock enable is low must not land.
        ce <= 1'b0;
        bus(1'b1, IDX_COUNT, 32'h55);
        ce <= 1'b1;
        rchk("frozen write", IDX_COUNT, 8'h0);
        bus(1'b1, IDX_OPCODE, 32'hec);
        repeat (3) @(negedge hclk);
        `CHK("foreign opcode", 1'b0, busy)
        @(posedge hclk);
    endtask

    task automatic test_opcodes;
        logic [7:0] ops [5];
        logic [7:0] dh;
        logic [27:0] ex;
        ops = '{OP_WRITE, OP_WRITE_ALT, OP_WRITE_NO_ERASE, OP_WRITE_VERIFY,
                OP_MULTI_NO_ERASE};
        for (int i = 0; i < 5; i++)
        begin
            dh = 8'ha0 | (i[0] ? 8'h40 : 8'h0) | 8'(i);
            ex = {dh[3:0], 8'h0b, 8'h9a, 8'(i + 1)};
            start(ops[i], 8'h1, 8'(i + 1), 8'h9a, 8'h0b, dh);
            sector(16'(i * 16'h111));
            `CHK("lba", ex, media_lba)
            `CHK("lba mode", i[0], media_lba_mode)
            rchk("done flag", IDX_IRQ_STAT, 8'h2);
            `CHK("masked irq", 1'b0, irq)
            bus(1'b1, IDX_IRQ_EN, 32'h7);
            repeat (2) @(negedge hclk);
            `CHK("irq on", 1'b1, irq)
            @(posedge hclk);
            bus(1'b1, IDX_IRQ_CLR, 32'h7);
            bus(1'b1, IDX_IRQ_EN, 32'h0);
            rchk("cleared", IDX_IRQ_STAT, 8'h0);
        end
    endtask

    task automatic test_multi;
        bus(1'b1, IDX_IRQ_EN, 32'h7);
        start(OP_WRITE, 8'h2, 8'hff, 8'h12, 8'h34, 8'he5);
        sector(16'h1000);
        `CHK("drq next", 1'b1, drq)
        `CHK("lba first", 28'h53412ff, media_lba)
        rchk("next flag", IDX_IRQ_STAT, 8'h1);
        `CHK("irq next", 1'b1, irq)
        bus(1'b1, IDX_IRQ_CLR, 32'h1);
        delay <= 8'hc8;
        sector(16'h2000);
        `CHK("lba second", 28'h5341300, media_lba)
        `CHK("drq done", 1'b0, drq)
        rchk("done flag", IDX_IRQ_STAT, 8'h2);
        bus(1'b1, IDX_IRQ_CLR, 32'h7);
        delay <= 8'h4;
    endtask

    // A zero count that fails on its second sector must leave 255 behind.
    task automatic test_error;
        start(OP_WRITE_VERIFY, 8'h0, 8'h10, 8'h0, 8'h0, 8'he0);
        sector(16'h3000);
        bus(1'b1, IDX_IRQ_CLR, 32'h7);
        fail_req <= 1'b1;
        sector(16'h4000);
        fail_req <= 1'b0;
        `CHK("fail lba", 28'h0000011, media_lba)
        rchk("err status", IDX_STATUS, 8'h4);
        rchk("err flag", IDX_IRQ_STAT, 8'h4);
        rchk("residual", IDX_COUNT, 8'hff);
        rchk("fail sector", IDX_SECTOR, 8'h11);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (50000) @(posedge hclk);
        mismatches++;
        final_report();
    end

    initial
    begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        test_reset();
        test_opcodes();
        test_multi();
        test_error();
        final_report();
    end

endmodule
